// ### core/pcau_pkg.sv
// package: register map, field layout and types of the compare/add unit
package pcau_pkg;

   localparam logic [7:0]  ACC_OFS       = 8'h00;
   localparam logic [7:0]  OPERAND_OFS   = 8'h04;
   localparam logic [7:0]  CMD_OFS       = 8'h08;
   localparam logic [7:0]  FLAGS_OFS     = 8'h0C;
   localparam logic [7:0]  INT_STAT_OFS  = 8'h10;
   localparam logic [7:0]  INT_MASK_OFS  = 8'h14;
   localparam logic [7:0]  OP_COUNT_OFS  = 8'h18;

   localparam int          CMD_OP_LSB    = 0;
   localparam int          CMD_SRC_LSB   = 2;
   localparam int          CMD_PTR_BAD   = 4;
   localparam int          CMD_REJECTED  = 5;
   localparam int          EV_DONE       = 12;
   localparam int          EV_REJECT     = 13;
   localparam int          STAT_W        = 14;

   localparam logic [31:0] ACC_RST       = 32'h0000_0000;
   localparam logic [31:0] OPERAND_RST   = 32'h0000_0000;
   localparam logic [13:0] INT_MASK_RST  = 14'h0000;
   localparam logic [31:0] FP_QNAN       = 32'h7FC0_0000;
   localparam logic [7:0]  FP_EXP_MAX    = 8'hFF;

   typedef enum logic [1:0] {
      real_compare_op,
      bcd_add_16_op,
      bcd_add_32_op,
      real_add_op
   } pcau_op_t;

   typedef enum logic [1:0] {
      src_word,
      src_pointer,
      src_constant,
      src_spare
   } pcau_src_t;

   // bit 0 is less_flag, bit 11 is non_bcd_flag
   typedef struct packed {
      logic non_bcd_flag;
      logic underflow_flag;
      logic sign_error_flag;
      logic invalid_float_flag;
      logic pointer_invalid_flag;
      logic negative_flag;
      logic carry32_flag;
      logic carry16_flag;
      logic zero_flag;
      logic greater_flag;
      logic equal_flag;
      logic less_flag;
   } pcau_flags_t;

endpackage

// ### core/pcau_unit.sv
// compare/add unit with its ahb-lite register slave and interrupt
`timescale 1ns/1ps
`default_nettype none

module pcau_unit (
   input  wire logic               clock_in,
   input  wire logic               reset_in,
   input  wire logic               hsel_in,
   input  wire logic [31:0]        haddr_in,
   input  wire logic [1:0]         htrans_in,
   input  wire logic               hwrite_in,
   input  wire logic [2:0]         hsize_in,
   input  wire logic [31:0]        hwdata_in,
   input  wire logic               hready_in,
   output logic      [31:0]        hrdata_out,
   output logic                    hreadyout_out,
   output logic                    hresp_out,
   output logic                    irq_out,
   output pcau_pkg::pcau_flags_t   flags_out,
   output logic      [31:0]        acc_out
);

   // ---- arithmetic helpers

   // eight-digit decimal add; returns {carry32, carry16, sum}
   function automatic logic [33:0] bcd_add(input logic [31:0] a,
                                           input logic [31:0] b);
      logic [31:0] s;
      logic        c;
      logic        c16;
      logic [4:0]  d;
      s   = 32'h0000_0000;
      c   = 1'b0;
      c16 = 1'b0;
      d   = 5'h00;
      for (int i = 0; i < 8; i++) begin
         d = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
         // decimal adjust; wraps on bad digits, which non_bcd reports
         if (d > 5'h09) begin
            d = d + 5'h06;
            c = 1'b1;
         end else begin
            c = 1'b0;
         end
         s[4*i +: 4] = d[3:0];
         if (i == 3) begin
            c16 = c;
         end
      end
      return {c, c16, s};
   endfunction

   function automatic logic non_bcd(input logic [31:0] x);
      logic r;
      r = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (x[4*i +: 4] > 4'h9) begin
            r = 1'b1;
         end
      end
      return r;
   endfunction

   // ordering key: unsigned compare of keys orders the reals,
   // with both zeros equal and every pair giving one answer
   function automatic logic [31:0] fp_key(input logic [31:0] v);
      logic [31:0] k;
      if (v[30:0] == 31'h0000_0000) begin
         k = 32'h8000_0000;
      end else if (v[31]) begin
         k = ~v;
      end else begin
         k = {1'b1, v[30:0]};
      end
      return k;
   endfunction

   // ieee single add, truncating; returns {underflow, overflow, sum}
   // denormal results are flushed to signed zero and reported
   function automatic logic [33:0] fp_add(input logic [31:0] a,
                                          input logic [31:0] b);
      logic [31:0] x;
      logic [31:0] y;
      logic [31:0] r;
      logic [26:0] mx;
      logic [26:0] my;
      logic [27:0] s;
      logic        uf;
      logic        ov;
      int          ex;
      int          ey;
      int          e;
      int          d;
      x  = a;
      y  = b;
      uf = 1'b0;
      ov = 1'b0;
      if (x[30:0] < y[30:0]) begin
         x = b;
         y = a;
      end
      ex = (x[30:23] == 8'h00) ? 1 : int'(x[30:23]);
      ey = (y[30:23] == 8'h00) ? 1 : int'(y[30:23]);
      mx = {x[30:23] != 8'h00, x[22:0], 3'b000};
      my = {y[30:23] != 8'h00, y[22:0], 3'b000};
      d  = ex - ey;
      my = (d > 26) ? 27'h000_0000 : my >> d;
      if (x[31] == y[31]) begin
         s = {1'b0, mx} + {1'b0, my};
      end else begin
         s = {1'b0, mx} - {1'b0, my};
      end
      e = ex;
      if (s[27]) begin
         s = s >> 1;
         e = e + 1;
      end
      for (int i = 0; i < 26; i++) begin
         if (!s[26] && s != 28'h000_0000 && e > 1) begin
            s = s << 1;
            e = e - 1;
         end
      end
      if (s == 28'h000_0000) begin
         r = 32'h0000_0000;
      end else if (e >= 255) begin
         ov = 1'b1;
         r  = {x[31], pcau_pkg::FP_EXP_MAX, 23'h00_0000};
      end else if (!s[26]) begin
         uf = 1'b1;
         r  = {x[31], 31'h0000_0000};
      end else begin
         r = {x[31], 8'(e), s[25:3]};
      end
      return {uf, ov, r};
   endfunction

   // ---- bus slave state

   logic                  wr_pend;
   logic [7:0]            wr_addr;
   logic [31:0]           acc;
   logic [31:0]           operand;
   logic [5:0]            last_cmd;
   logic [31:0]           op_count;
   logic [13:0]           int_stat;
   logic [13:0]           int_mask;
   pcau_pkg::pcau_flags_t flags;

   logic                  take;
   logic                  exec;
   logic                  w1c;
   pcau_pkg::pcau_op_t    op;
   pcau_pkg::pcau_src_t   src;
   logic                  ptr_bad;

   // hsize is not checked: only whole-word transfers are issued
   assign take    = hsel_in & htrans_in[1] & hready_in;
   assign exec    = wr_pend && wr_addr == pcau_pkg::CMD_OFS;
   assign w1c     = wr_pend && wr_addr == pcau_pkg::INT_STAT_OFS;
   assign op      = pcau_pkg::pcau_op_t'(hwdata_in[pcau_pkg::CMD_OP_LSB +: 2]);
   assign src     = pcau_pkg::pcau_src_t'(hwdata_in[pcau_pkg::CMD_SRC_LSB+:2]);
   assign ptr_bad = hwdata_in[pcau_pkg::CMD_PTR_BAD];

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
      end else begin
         wr_pend <= take & hwrite_in;
         if (take) begin
            wr_addr <= haddr_in[7:0];
         end
      end
   end

   // zero wait states, never an error
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end else begin
         hreadyout_out <= 1'b1;
         hresp_out     <= 1'b0;
      end
   end

   // ---- operation datapath, evaluated during the command data phase

   logic [31:0]           next_acc;
   pcau_pkg::pcau_flags_t next_flags;
   logic                  next_reject;
   logic [33:0]           bsum;
   logic [33:0]           fsum;
   logic                  bad_in;
   logic [31:0]           ka;
   logic [31:0]           kb;

   always_comb begin
      next_acc    = acc;
      next_flags  = flags;
      next_reject = 1'b0;
      bsum        = 34'h0_0000_0000;
      fsum        = 34'h0_0000_0000;
      bad_in      = 1'b0;
      ka          = fp_key(acc);
      kb          = fp_key(operand);
      // only the flags an operation owns are written; others hold
      case (op)
         pcau_pkg::real_compare_op: begin
            if (src == pcau_pkg::src_spare) begin
               next_reject = 1'b1;
            end else if (src == pcau_pkg::src_pointer && ptr_bad) begin
               next_flags.pointer_invalid_flag = 1'b1;
            end else begin
               next_flags.pointer_invalid_flag = 1'b0;
               next_flags.less_flag    = ka < kb;
               next_flags.equal_flag   = ka == kb;
               next_flags.greater_flag = ka > kb;
            end
         end
         pcau_pkg::bcd_add_16_op: begin
            if (src == pcau_pkg::src_constant ||
                src == pcau_pkg::src_spare) begin
               next_reject = 1'b1;
            end else begin
               bsum = bcd_add({16'h0000, acc[15:0]},
                              {16'h0000, operand[15:0]});
               next_acc = {16'h0000, bsum[15:0]};
               next_flags.carry16_flag = bsum[32];
               next_flags.carry32_flag = 1'b0;
               next_flags.non_bcd_flag =
                  non_bcd({16'h0000, acc[15:0]}) |
                  non_bcd({16'h0000, operand[15:0]});
               next_flags.zero_flag     = next_acc == 32'h0000_0000;
               next_flags.negative_flag = next_acc[31];
            end
         end
         pcau_pkg::bcd_add_32_op: begin
            if (src == pcau_pkg::src_spare) begin
               next_reject = 1'b1;
            end else begin
               // word pair or constant both arrive in the operand reg
               bsum = bcd_add(acc, operand);
               next_acc = bsum[31:0];
               next_flags.carry16_flag = bsum[32];
               next_flags.carry32_flag = bsum[33];
               next_flags.non_bcd_flag =
                  non_bcd(acc) | non_bcd(operand);
               next_flags.zero_flag     = next_acc == 32'h0000_0000;
               next_flags.negative_flag = next_acc[31];
            end
         end
         pcau_pkg::real_add_op: begin
            if (src == pcau_pkg::src_spare) begin
               next_reject = 1'b1;
            end else if (src == pcau_pkg::src_pointer && ptr_bad) begin
               next_flags.pointer_invalid_flag = 1'b1;
            end else begin
               next_flags.pointer_invalid_flag = 1'b0;
               // raw bit patterns, no integer or decimal conversion
               bad_in = acc[30:23] == pcau_pkg::FP_EXP_MAX ||
                        operand[30:23] == pcau_pkg::FP_EXP_MAX;
               fsum = fp_add(acc, operand);
               next_acc = bad_in ? pcau_pkg::FP_QNAN : fsum[31:0];
               next_flags.invalid_float_flag =
                  next_acc[30:23] == pcau_pkg::FP_EXP_MAX;
               // overflow leaves a sum whose sign cannot be trusted
               next_flags.sign_error_flag = fsum[32] & ~bad_in;
               next_flags.underflow_flag  = fsum[33] & ~bad_in;
               next_flags.zero_flag     =
                  next_acc[30:0] == 31'h0000_0000;
               next_flags.negative_flag =
                  next_acc[31] & ~next_flags.zero_flag;
            end
         end
         default: begin
            next_reject = 1'b1;
         end
      endcase
      if (op == pcau_pkg::bcd_add_16_op || op == pcau_pkg::bcd_add_32_op)
      begin
         if (!next_reject) begin
            next_flags.zero_flag     = next_acc == 32'h0000_0000;
            next_flags.negative_flag = next_acc[31];
         end
      end
   end

   // ---- registers software writes

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         acc <= pcau_pkg::ACC_RST;
      end else if (exec && !next_reject) begin
         acc <= next_acc;
      end else if (wr_pend && wr_addr == pcau_pkg::ACC_OFS) begin
         acc <= hwdata_in;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         operand <= pcau_pkg::OPERAND_RST;
      end else if (wr_pend && wr_addr == pcau_pkg::OPERAND_OFS) begin
         operand <= hwdata_in;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         int_mask <= pcau_pkg::INT_MASK_RST;
      end else if (wr_pend && wr_addr == pcau_pkg::INT_MASK_OFS) begin
         int_mask <= hwdata_in[pcau_pkg::STAT_W-1:0];
      end
   end

   // ---- state the block keeps on each operation

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         flags    <= '0;
         last_cmd <= 6'h00;
         op_count <= 32'h0000_0000;
      end else if (exec) begin
         if (!next_reject) begin
            flags    <= next_flags;
            op_count <= op_count + 32'h0000_0001;
         end
         last_cmd <= {next_reject, hwdata_in[4:0]};
      end
   end

   // event bits: a flag raised by this operation, done, refused
   logic [13:0] events;
   logic [13:0] rising;

   always_comb begin
      rising = {2'b00, next_flags & ~flags};
      events = 14'h0000;
      if (exec) begin
         events                      = next_reject ? 14'h0000 : rising;
         events[pcau_pkg::EV_DONE]   = ~next_reject;
         events[pcau_pkg::EV_REJECT] = next_reject;
      end
   end

   // a new event wins over a write-one clear in the same cycle
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         int_stat <= 14'h0000;
      end else begin
         int_stat <= (int_stat
                      & ~(w1c ? hwdata_in[13:0] : 14'h0000))
                     | events;
      end
   end

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         irq_out   <= 1'b0;
         flags_out <= '0;
         acc_out   <= pcau_pkg::ACC_RST;
      end else begin
         irq_out   <= |(int_stat & int_mask);
         flags_out <= flags;
         acc_out   <= acc;
      end
   end

   // ---- read data, sampled in the address phase

   logic [31:0] rd_data;

   always_comb begin
      case (haddr_in[7:0])
         pcau_pkg::ACC_OFS:      rd_data = acc;
         pcau_pkg::OPERAND_OFS:  rd_data = operand;
         pcau_pkg::CMD_OFS:      rd_data = {26'h000_0000, last_cmd};
         pcau_pkg::FLAGS_OFS:    rd_data = {20'h0_0000, flags};
         pcau_pkg::INT_STAT_OFS: rd_data = {18'h0_0000, int_stat};
         pcau_pkg::INT_MASK_OFS: rd_data = {18'h0_0000, int_mask};
         pcau_pkg::OP_COUNT_OFS: rd_data = op_count;
         default:                rd_data = 32'h0000_0000;
      endcase
   end

   // limitation: a read right after a write to the same register
   // returns the old value, since data is taken in the address phase
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         hrdata_out <= 32'h0000_0000;
      end else if (take && !hwrite_in) begin
         hrdata_out <= rd_data;
      end
   end

endmodule

`default_nettype wire

// ### verif/pcau_host.sv
// partner model: bus master standing in for the instruction sequencer
`timescale 1ns/1ps
`default_nettype none

module pcau_host (
   input  wire logic        clock_in,
   input  wire logic        hready_in,
   input  wire logic [31:0] hrdata_in,
   output logic             hsel_out,
   output logic [31:0]      haddr_out,
   output logic [1:0]       htrans_out,
   output logic             hwrite_out,
   output logic [2:0]       hsize_out,
   output logic [31:0]      hwdata_out,
   output logic [31:0]      rd_data_out,
   output int               rd_seq_out
);
   initial begin
      hsel_out = 1'b0;
      haddr_out = 32'h0000_0000;
      htrans_out = 2'b00;
      hwrite_out = 1'b0;
      hsize_out = 3'h2;
      hwdata_out = 32'h0000_0000;
      rd_data_out = 32'h0000_0000;
      rd_seq_out = 0;
   end

   // no pipelining: simpler, costs one idle cycle per transfer
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
      hsel_out <= 1'b1;
      htrans_out <= 2'b10;
      haddr_out <= {24'h00_0000, a};
      hwrite_out <= wr;
      @(posedge clock_in);
      while (hready_in !== 1'b1) @(posedge clock_in);
      hsel_out <= 1'b0;
      htrans_out <= 2'b00;
      hwdata_out <= wr ? d : ~hwdata_out;
      @(posedge clock_in);
      while (hready_in !== 1'b1) @(posedge clock_in);
      if (!wr) begin
         rd_data_out <= hrdata_in;
         rd_seq_out <= rd_seq_out + 1;
      end
   endtask
endmodule

`default_nettype wire

// ### verif/pcau_unit_monitor.sv
// checker: port-level properties of the compare/add unit
`timescale 1ns/1ps
`default_nettype none

module pcau_unit_monitor (
   input wire logic                  clock_in,
   input wire logic                  reset_in,
   input wire logic                  hsel_in,
   input wire logic [31:0]           haddr_in,
   input wire logic [1:0]            htrans_in,
   input wire logic                  hwrite_in,
   input wire logic [31:0]           hwdata_in,
   input wire logic                  hready_in,
   input wire logic                  hreadyout_out,
   input wire logic                  hresp_out,
   input wire pcau_pkg::pcau_flags_t flags_out,
   input wire logic [31:0]           acc_out
);
   logic take;
   logic cmd_take;
   logic acc_take;
   assign take = hsel_in && htrans_in[1] && hready_in && hwrite_in;
   assign cmd_take = take && haddr_in[7:0] == pcau_pkg::CMD_OFS;
   assign acc_take = take && haddr_in[7:0] == pcau_pkg::ACC_OFS;

   default clocking @(posedge clock_in); endclocking
   default disable iff (reset_in);

   // command word is seen in the data phase after the address phase
   sequence s_cmp_ok;
      cmd_take ##1 (hwdata_in[1:0] == 2'b00 && hwdata_in[3:2] != 2'b11
                    && hwdata_in[4:2] != 3'b101);
   endsequence
   sequence s_bcd16_ok;
      cmd_take ##1 (hwdata_in[3:0] == 4'h1 || hwdata_in[3:0] == 4'h5);
   endsequence
   sequence s_bcd_ok;
      cmd_take ##1 (hwdata_in[3:0] == 4'h1 || hwdata_in[3:0] == 4'h5
                    || (hwdata_in[1:0] == 2'b10 && hwdata_in[3:2] != 2'b11));
   endsequence
   sequence s_refused;
      cmd_take ##1 (hwdata_in[3:2] == 2'b11 || hwdata_in[3:0] == 4'h9);
   endsequence
   sequence s_ptr_bad;
      cmd_take ##1 (hwdata_in[4:2] == 3'b101
                    && hwdata_in[1] == hwdata_in[0]);
   endsequence

   a_ready_high: assert property (hreadyout_out)
      else $error("hreadyout dropped");
   a_resp_okay: assert property (!hresp_out)
      else $error("error response seen");
   // outputs are a registered copy: they move one edge after the op
   a_cmp_one: assert property (s_cmp_ok |=> ##1
      $onehot(flags_out[2:0]) && !flags_out.pointer_invalid_flag)
      else $error("compare flags not one-hot");
   a_flags_hold: assert property ($changed(flags_out) |->
      $past(cmd_take, 3)) else $error("flags moved without an op");
   a_acc_source: assert property ($changed(acc_out) |->
      $past(cmd_take, 3) || $past(acc_take, 3))
      else $error("acc moved without a write");
   a_bcd16_high: assert property (s_bcd16_ok |=> ##1
      acc_out[31:16] == 16'h0000 && !flags_out.carry32_flag)
      else $error("bcd16 upper half not cleared");
   a_bcd_zero_neg: assert property (s_bcd_ok |=> ##1
      flags_out.zero_flag == (acc_out == 32'h0000_0000)
      && flags_out.negative_flag == acc_out[31])
      else $error("bcd zero or negative flag wrong");
   a_refuse_hold: assert property (s_refused |=> ##1
      $stable(acc_out) && $stable(flags_out))
      else $error("refused op changed state");
   a_ptr_bad: assert property (s_ptr_bad |=> ##1
      flags_out.pointer_invalid_flag && $stable(acc_out))
      else $error("bad pointer not flagged");
endmodule

bind pcau_unit pcau_unit_monitor u_monitor (
   .clock_in(clock_in), .reset_in(reset_in), .hsel_in(hsel_in),
   .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
   .hwdata_in(hwdata_in), .hready_in(hready_in),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
   .flags_out(flags_out), .acc_out(acc_out)
);

`default_nettype wire

// ### verif/plc_compare_add_unit_tb.sv
// testbench: drives the unit over its bus and checks the unmasked bits of each result
`timescale 1ns/1ps
`default_nettype none

module plc_compare_add_unit_tb;
   typedef struct { logic [31:0] v; logic [31:0] m; } pcau_exp_t;
   localparam logic [11:0] CM = 12'h087;
   localparam logic [11:0] BM = 12'h878;
   localparam logic [11:0] RM = 12'h7C8;
   logic                  clock_in;
   logic                  reset_in;
   logic                  hsel;
   logic [31:0]           haddr;
   logic [1:0]            htrans;
   logic                  hwrite;
   logic [2:0]            hsize;
   logic [31:0]           hwdata;
   logic [31:0]           hrdata;
   logic                  hready;
   logic                  hresp;
   logic                  irq;
   pcau_pkg::pcau_flags_t flags;
   logic [31:0]           acc;
   logic [31:0]           rd_data;
   logic [31:0]           a;
   logic [31:0]           b;
   logic [32:0]           s;
   logic [11:0]           ef;
   logic [11:0]           fm;
   logic [31:0]           am;
   int                    rd_seq;
   int                    fails;
   int                    samples_checked;
   int                    seed;
   pcau_exp_t             exp_q[$];
   pcau_exp_t             e_now;

   pcau_unit uut (.clock_in(clock_in), .reset_in(reset_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
      .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready),
      .hresp_out(hresp), .irq_out(irq), .flags_out(flags), .acc_out(acc));
   pcau_host host (.clock_in(clock_in), .hready_in(hready),
      .hrdata_in(hrdata), .hsel_out(hsel), .haddr_out(haddr),
      .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
      .hwdata_out(hwdata), .rd_data_out(rd_data), .rd_seq_out(rd_seq));

   initial begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(rd_seq) begin
      e_now = exp_q.pop_front();
      check(rd_data & e_now.m, e_now.v & e_now.m);
   end

   task automatic rd(input logic [7:0] ad, input logic [31:0] v, m);
      exp_q.push_back('{v, m});
      host.xfer(1'b0, ad, 32'h0000_0000);
   endtask

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      host.xfer(1'b1, ad, d);
   endtask

   // owned flags take the new value, all the others must hold
   task automatic run_op(input logic [4:0] c, input logic [31:0] x, y, e,
                         input logic [11:0] own, v);
      wr(pcau_pkg::ACC_OFS, x);
      wr(pcau_pkg::OPERAND_OFS, y);
      wr(pcau_pkg::CMD_OFS, {27'h0, c});
      ef = (ef & ~own) | (v & own);
      rd(pcau_pkg::FLAGS_OFS, {20'h0, ef}, {20'h0, fm});
      rd(pcau_pkg::ACC_OFS, e, am);
      check({20'h0, flags & fm}, {20'h0, ef & fm});
      check(acc & am, e & am);
   endtask

   function automatic logic [32:0] bcd_sum(input logic [31:0] x, y);
      logic [32:0] r;
      int d;
      r = 33'h0;
      for (int i = 0; i < 8; i++) begin
         d = x[4*i+:4] + y[4*i+:4] + r[32];
         r[32] = d > 9;
         r[4*i+:4] = 4'(r[32] ? d - 10 : d);
      end
      return r;
   endfunction

   // ordering key for nonzero finite floats
   function automatic logic [31:0] fkey(input logic [31:0] x);
      return x[31] ? ~x : {1'b1, x[30:0]};
   endfunction

   initial begin
      reset_in = 1'b1;
      seed = 26;
      ef = 12'h000;
      fm = 12'hFFF;
      am = 32'hFFFF_FFFF;
      repeat (8) @(posedge clock_in);
      reset_in <= 1'b0;
      @(posedge clock_in);
      rd(pcau_pkg::ACC_OFS, 32'h0, 32'hFFFF_FFFF);
      rd(pcau_pkg::FLAGS_OFS, 32'h0, 32'hFFFF_FFFF);
      rd(pcau_pkg::INT_MASK_OFS, 32'h0, 32'hFFFF_FFFF);
      rd(8'h1C, 32'h0, 32'hFFFF_FFFF);
      wr(pcau_pkg::INT_MASK_OFS, 32'h0000_1000);
      run_op(5'h00, 32'h40E0_0000, 32'h40C0_0000, 32'h40E0_0000, CM, 12'h004);
      check({31'h0, irq}, 32'h1);
      run_op(5'h08, 32'h40C0_0000, 32'h40E0_0000, 32'h40C0_0000, CM, 12'h001);
      run_op(5'h04, 32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0000, CM, 12'h002);
      run_op(5'h14, 32'hC000_0000, 32'h3F80_0000, 32'hC000_0000, 12'h080, 12'h080);
      for (int i = 0; i < 8; i++) begin
         a = $random(seed);
         b = $random(seed);
         a[30] = ~a[29];
         b[30] = (i == 1) ? b[30] : ~b[29];
         if (i == 0) b = a;
         run_op(5'h00, a, b, a, CM, {9'h0, fkey(a) > fkey(b), a == b, fkey(a) < fkey(b)});
      end
      fm = 12'hFEF;
      run_op(5'h02, 32'h9999_9999, 32'h0000_0001, 32'h0, BM, 12'h028);
      run_op(5'h06, 32'h1234_5678, 32'h8765_4321, 32'h9999_9999, BM, 12'h040);
      run_op(5'h0A, 32'h0000_0001, 32'h0999_9999, 32'h1000_0000, BM, 12'h000);
      for (int i = 0; i < 8; i++) begin
         for (int k = 0; k < 8; k++) begin
            a[4*k+:4] = 4'(($random(seed) & 32'hFF) % 10);
            b[4*k+:4] = 4'(($random(seed) & 32'hFF) % 10);
         end
         s = bcd_sum(a, b);
         run_op({1'b0, 2'(i % 3), 2'b10}, a, b, s[31:0], BM, {5'h0, s[31], s[32], 1'b0, s[31:0] == 0, 3'h0});
      end
      fm = 12'hFFF;
      run_op(5'h01, 32'h1234_9999, 32'h0000_0001, 32'h0, BM, 12'h018);
      run_op(5'h05, 32'h0000_1234, 32'h5555_5678, 32'h0000_6912, BM, 12'h000);
      fm = 12'h800;
      am = 32'h0;
      run_op(5'h01, 32'h0000_00A0, 32'h0000_0001, 32'h0, 12'h800, 12'h800);
      fm = 12'hFFF;
      am = 32'hFFFF_FFFF;
      run_op(5'h09, 32'h0000_1111, 32'h2222, 32'h0000_1111, 12'h0, 12'h0);
      rd(pcau_pkg::CMD_OFS, 32'h29, 32'h3F);
      rd(pcau_pkg::INT_STAT_OFS, 32'h2000, 32'h2000);
      run_op(5'h05, 32'h0000_0001, 32'h0000_0001, 32'h0000_0002, BM, 12'h000);
      run_op(5'h0B, 32'h3F80_0000, 32'h4000_0000, 32'h4040_0000, RM, 12'h000);
      run_op(5'h03, 32'h3F80_0000, 32'hC040_0000, 32'hC000_0000, RM, 12'h040);
      am = 32'h7FFF_FFFF;
      run_op(5'h07, 32'h3F80_0000, 32'hBF80_0000, 32'h0, RM, 12'h008);
      run_op(5'h03, 32'h0080_0000, 32'h8080_0001, 32'h0, RM, 12'h408);
      am = 32'hFFFF_FFFF;
      run_op(5'h03, 32'h7F7F_FFFF, 32'h7F7F_FFFF, 32'h7F80_0000, RM, 12'h300);
      run_op(5'h03, 32'h7FC0_0001, 32'h3F80_0000, pcau_pkg::FP_QNAN, RM, 12'h100);
      run_op(5'h17, 32'h3F80_0000, 32'h3F80_0000, 32'h3F80_0000, 12'h080, 12'h080);
      wr(pcau_pkg::INT_STAT_OFS, 32'hFFFF_FFFF);
      repeat (2) @(posedge clock_in);
      check({31'h0, irq}, 32'h0);
      wr(pcau_pkg::INT_MASK_OFS, 32'h0);
      run_op(5'h00, 32'h3F80_0000, 32'h4000_0000, 32'h3F80_0000, CM, 12'h001);
      check({31'h0, irq}, 32'h0);
      rd(pcau_pkg::INT_STAT_OFS, 32'h1000, 32'h1000);
      repeat (4) @(posedge clock_in);
      end_of_test();
   end

   // the run needs some 400 cycles
   initial begin
      repeat (20000) @(posedge clock_in);
      fails++;
      end_of_test();
   end
endmodule

`default_nettype wire
